/* dv/acsr_regs_sva.sv */
// Purpose: port timing checks of the correction and slot register bank
// Assumes: zero wait apb, byte address = 4 * word index
// Notes:   bound into acsr_regs
module acsr_regs_sva (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        conv_valid,
  input wire logic        corr_valid,
  input wire logic [6:0]  slot_index,
  input wire logic [3:0]  slot_input_select
);
  wire [9:0] ix = paddr[11:2];
  wire       rd = pready && !pwrite && paddr[1:0] == 2'h0;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_calm;
    $stable(slot_index) && !(psel && penable && pwrite);
  endsequence
  // ==========
  // assertions
  AST_RDY: assert property (s_setup |=> pready && !$past(pready)) else $error("apb answer late");
  AST_OFF: assert property (rd && !ix[0] && ix >= 10'h0a0 && ix <= 10'h0be |-> !pslverr && prdata[31:16] == 16'h0)
    else $error("offset read bad");
  AST_GAIN: assert property (rd && !ix[0] && ix >= 10'h0c0 && ix <= 10'h0de |-> !pslverr && prdata[31:16] == 16'h0)
    else $error("gain read bad");
  AST_SLOT: assert property (rd && ix >= 10'h100 && ix <= 10'h17f |-> !pslverr && prdata[31:4] == 28'h0)
    else $error("slot read bad");
  AST_SEL: assert property (s_calm [*3] |-> $stable(slot_input_select)) else $error("select moved");
  AST_CORR: assert property (conv_valid |=> corr_valid) else $error("result lost");
  AST_NOCORR: assert property (!conv_valid |=> !corr_valid) else $error("stray result");
endmodule
bind acsr_regs acsr_regs_sva chk_u (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .conv_valid, .corr_valid, .slot_index, .slot_input_select);

/* dv/tb_adc_channel_correction_slot_regs.sv */
// Purpose: self-checking bench of the correction and slot register bank
// Assumes: zero wait apb, byte address = 4 * word index
// Notes:   gain 0x8000 is unity, offset adds as two's complement
`include "acsr_defs.svh"
module tb_adc_channel_correction_slot_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] OB = `ACSR_OFF_FIRST;
  localparam logic [9:0] GB = `ACSR_GAIN_FIRST;
  localparam logic [9:0] SB = `ACSR_SLOT_FIRST;
  logic        sys_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, conv_valid = 1'h0;
  logic        pready, pslverr, corr_valid;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  conv_channel = 4'h0, corr_channel, slot_input_select;
  logic [15:0] conv_data = 16'h0, corr_data;
  logic [6:0]  slot_index = 7'h0;
  int          errors = 0, num_checks = 0;
  acsr_regs dut_u (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready,
    .pslverr, .conv_valid, .conv_channel, .conv_data, .corr_valid, .corr_channel, .corr_data, .slot_index,
    .slot_input_select);
  // ==========
  // helpers
  task automatic test_done(int extra = 0);
    errors += extra;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(logic w, logic [9:0] ix, logic [31:0] d, logic e = 1'h0);
    int i;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    i = 0;
    do
    begin
      @(posedge sys_clk);
      i++;
    end
    while (pready !== 1'h1 && i < 9);
    if (pready !== 1'h1)
      test_done(1);
    rd = prdata;
    chk("pslverr", 32'(e), 32'(pslverr));
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rc(logic [9:0] ix, logic [31:0] e, logic ee = 1'h0);
    apb(1'h0, ix, 32'h0, ee);
    chk("prdata", e, rd);
  endtask
  // ==========
  // scenarios
  task automatic t_reset;
    rc(OB, 32'h0);
    rc(GB + 10'h1e, 32'h8000);
    rc(SB + 10'h7f, 32'h0);
  endtask
  task automatic t_corr;
    apb(1'h1, OB + 10'h6, 32'h10);
    apb(1'h1, GB + 10'h6, 32'h4000);
    @(posedge sys_clk);
    conv_valid <= 1'h1;
    conv_channel <= 4'h3;
    conv_data <= 16'h1000;
    @(posedge sys_clk);
    conv_channel <= 4'h4;
    conv_data <= 16'hfff0;
    @(posedge sys_clk);
    conv_valid <= 1'h0;
    chk("corr", 32'h130810, {11'h0, corr_valid, corr_channel, corr_data});
    @(posedge sys_clk);
    chk("corr", 32'h14fff0, {11'h0, corr_valid, corr_channel, corr_data});
  endtask
  task automatic t_slot;
    for (int n = 0; n < 16; n++)
      apb(1'h1, SB + 10'(8 * n + 7), 32'hfffffff0 | n);
    for (int n = 0; n < 16; n++)
    begin
      rc(SB + 10'(8 * n + 7), 32'(n));
      slot_index <= 7'(8 * n + 7);
      repeat (2) @(posedge sys_clk);
      chk("select", 32'(n), 32'(slot_input_select));
    end
  endtask
  task automatic t_rw;
    for (int n = 0; n < 16; n++)
    begin
      apb(1'h1, OB + 10'(2 * n), 32'hffff8000 | n);
      apb(1'h1, GB + 10'(2 * n), 32'h1230 + n);
    end
    for (int n = 0; n < 16; n++)
    begin
      rc(OB + 10'(2 * n), 32'h8000 | n);
      rc(GB + 10'(2 * n), 32'h1230 + n);
    end
    rc(OB + 10'h1, 32'h0, 1'h1);
  endtask
  initial
    forever #2.5 sys_clk = ~sys_clk;
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'h0;
    t_reset;
    t_corr;
    t_slot;
    t_rw;
    test_done;
  end
endmodule

/* logic/acsr_correct.sv */
// Purpose: combinational gain and offset correction of one conversion result
// Assumes: raw code unsigned, gain unsigned with 0x8000 as unity, offset two's complement
// Notes:   result saturates to 0x0000..0xffff
`include "acsr_defs.svh"

module acsr_correct (
  input  wire logic [15:0] raw_code,
  input  wire logic [15:0] gain_val,
  input  wire logic [15:0] offset_val,
  output logic      [15:0] corr_code
);

  logic        [31:0] product;
  logic signed [18:0] scaled;
  logic signed [18:0] summed;

  always_comb
  begin
    product = raw_code * gain_val;
    scaled  = signed'({2'b00, product[31:`ACSR_GAIN_SHIFT]});
    summed  = scaled + 19'(signed'(offset_val));
    if (summed < 19'sh0)
    begin
      corr_code = 16'h0000;
    end
    else if (summed > signed'({1'b0, `ACSR_CODE_MAX}))
    begin
      corr_code = 16'hffff;
    end
    else
    begin
      corr_code = summed[15:0];
    end
  end

endmodule

/* logic/acsr_defs.svh */
// Purpose: constants of the channel correction and slot register bank
// Assumes: apb with 32-bit data, registers at word index, byte address = 4 * index
// Notes:   indexes are word indexes, paddr[11:2]
`ifndef ACSR_DEFS_SVH
`define ACSR_DEFS_SVH

// ==========================================================
// register map (word indexes)
`define ACSR_OFF_FIRST   10'h0a0
`define ACSR_OFF_LAST    10'h0be
`define ACSR_GAIN_FIRST  10'h0c0
`define ACSR_GAIN_LAST   10'h0de
`define ACSR_SLOT_FIRST  10'h100
`define ACSR_SLOT_LAST   10'h17f

// ==========================================================
// reset values
`define ACSR_OFF_RST     16'h0000
`define ACSR_GAIN_RST    16'h8000
`define ACSR_SLOT_RST    4'h0

// ==========================================================
// sizes and correction scaling
`define ACSR_NCHAN       16
`define ACSR_NSLOT       128
`define ACSR_GAIN_SHIFT  15
`define ACSR_CODE_MAX    18'h0ffff

`endif

/* logic/acsr_pkg.sv */
// Purpose: types of the channel correction and slot register bank
// Assumes: acsr_defs.svh sizes
// Notes:   whole block state is one packed struct
package acsr_pkg;

  typedef struct packed {
    logic [15:0][15:0]  offs;
    logic [15:0][15:0]  gain;
    logic [127:0][3:0]  slot;
    logic               pready;
    logic [31:0]        prdata;
    logic               pslverr;
    logic               cvalid;
    logic [3:0]         cchan;
    logic [15:0]        cdata;
    logic [3:0]         slot_sel;
  } acsr_state_t;

endpackage

/* logic/acsr_regs.sv */
// Purpose: per-input offset and gain correction registers and sequencer slot registers
// Assumes: apb slave, zero wait states, one clock sys_clk, synchronous reset rst
// Notes:   conversion results are corrected and registered one cycle after conv_valid
//
// Behaviour
// - sixteen 16-bit offset registers from 0x00A0, step 2, reset zero, read/write.
// - each input's offset value adjusts every conversion result of that input.
// - sixteen 16-bit gain registers from 0x00C0, step 2, reset 0x8000, read/write.
// - each input's gain value scales every conversion result of that input.
// - 4-bit slot registers at 0x0100 through 0x017F, reset zero.
// - low four slot bits pick analog input k for that slot.
//
// Local design decision: the APB register port.
`include "acsr_defs.svh"

module acsr_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        conv_valid,
  input  wire logic [3:0]  conv_channel,
  input  wire logic [15:0] conv_data,
  output logic             corr_valid,
  output logic      [3:0]  corr_channel,
  output logic      [15:0] corr_data,
  input  wire logic [6:0]  slot_index,
  output logic      [3:0]  slot_input_select
);

  acsr_pkg::acsr_state_t st_ff;
  acsr_pkg::acsr_state_t nxt_st;
  logic [15:0]           corr_code;

  // ==========================================================
  // correction datapath
  acsr_correct u_correct (
    .raw_code   (conv_data),
    .gain_val   (st_ff.gain[conv_channel]),
    .offset_val (st_ff.offs[conv_channel]),
    .corr_code  (corr_code)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    logic [9:0]  widx;
    logic        hit_off;
    logic        hit_gain;
    logic        hit_slot;
    logic        bad;
    logic        wr;
    logic [3:0]  ch;
    logic [6:0]  sl;
    logic [31:0] rd;
    widx     = paddr[11:2];
    hit_off  = (widx >= `ACSR_OFF_FIRST) && (widx <= `ACSR_OFF_LAST) && !widx[0];
    hit_gain = (widx >= `ACSR_GAIN_FIRST) && (widx <= `ACSR_GAIN_LAST) && !widx[0];
    hit_slot = (widx >= `ACSR_SLOT_FIRST) && (widx <= `ACSR_SLOT_LAST);
    bad      = (paddr[1:0] != 2'h0) || !(hit_off || hit_gain || hit_slot);
    ch       = widx[4:1];
    sl       = widx[6:0];
    rd       = 32'h0000_0000;
    nxt_st   = st_ff;

    // read data and error prepared in setup, presented in access
    if (hit_off)
    begin
      rd = {16'h0000, st_ff.offs[ch]};
    end
    else if (hit_gain)
    begin
      rd = {16'h0000, st_ff.gain[ch]};
    end
    else if (hit_slot)
    begin
      rd = {28'h000_0000, st_ff.slot[sl]};
    end
    nxt_st.pready  = psel && !penable;
    nxt_st.prdata  = (psel && !penable && !pwrite && !bad) ? rd : 32'h0000_0000;
    nxt_st.pslverr = psel && !penable && bad;

    // write at the completing access edge
    wr = psel && penable && pwrite && st_ff.pready && !st_ff.pslverr;
    if (wr && hit_off)
    begin
      if (pstrb[0])
      begin
        nxt_st.offs[ch][7:0] = pwdata[7:0];
      end
      if (pstrb[1])
      begin
        nxt_st.offs[ch][15:8] = pwdata[15:8];
      end
    end
    if (wr && hit_gain)
    begin
      if (pstrb[0])
      begin
        nxt_st.gain[ch][7:0] = pwdata[7:0];
      end
      if (pstrb[1])
      begin
        nxt_st.gain[ch][15:8] = pwdata[15:8];
      end
    end
    if (wr && hit_slot && pstrb[0])
    begin
      nxt_st.slot[sl] = pwdata[3:0];
    end

    // corrected result per input
    nxt_st.cvalid = conv_valid;
    if (conv_valid)
    begin
      nxt_st.cchan = conv_channel;
      nxt_st.cdata = corr_code;
    end

    // slot slot_index selects the input held in its slot register
    nxt_st.slot_sel = st_ff.slot[slot_index];

    if (rst)
    begin
      nxt_st = '0;
      for (int i = 0; i < `ACSR_NCHAN; i++)
      begin
        nxt_st.offs[i] = `ACSR_OFF_RST;
        nxt_st.gain[i] = `ACSR_GAIN_RST;
      end
      for (int j = 0; j < `ACSR_NSLOT; j++)
      begin
        nxt_st.slot[j] = `ACSR_SLOT_RST;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk)
  begin
    st_ff <= nxt_st;
  end

  assign prdata            = st_ff.prdata;
  assign pready            = st_ff.pready;
  assign pslverr           = st_ff.pslverr;
  assign corr_valid        = st_ff.cvalid;
  assign corr_channel      = st_ff.cchan;
  assign corr_data         = st_ff.cdata;
  assign slot_input_select = st_ff.slot_sel;

endmodule
